/* src/retry_latch_consts.svh */
`ifndef RETRY_LATCH_CONSTS_SVH
`define RETRY_LATCH_CONSTS_SVH

// ==========================================================
// clock and channel layout
`define CLK_HZ            25000000
`define CHANNELS          2
`define SEL_WIDTH         1

// ==========================================================
// retry counter
`define RESTART_LIMIT     6
`define COUNT_WIDTH       3

// ==========================================================
// input-low clear delay, nominal figure, in ms
`define CLEAR_DELAY_MS    70
`define CLEAR_DELAY_CYC   (`CLEAR_DELAY_MS * (`CLK_HZ / 1000))
`define CLEAR_CNT_WIDTH   21

// ==========================================================
// forced clear pulse width, in us
`define PULSE_MIN_US      50
`define PULSE_MAX_US      150
`define PULSE_MIN_CYC     (`PULSE_MIN_US * (`CLK_HZ / 1000000))
`define PULSE_MAX_CYC     (`PULSE_MAX_US * (`CLK_HZ / 1000000))
`define PULSE_CNT_WIDTH   13

// ==========================================================
// host sequencing
`define HOST_PREP_CYC     4

`endif

/* src/retry_latch_pkg.sv */
package retry_latch_pkg;

  // per channel protection state
  typedef enum logic [1:0] {
    CH_OFF   = 2'b00,
    CH_ON    = 2'b01,
    CH_RETRY = 2'b10,
    CH_LATCH = 2'b11
  } chan_state_type;

  // host forced clear sequencer
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_PREP  = 2'b01,
    HS_PULSE = 2'b10,
    HS_DONE  = 2'b11
  } host_state_type;

endpackage

/* src/retry_latch_if.sv */
`timescale 1ns/1ps
`default_nettype none
// pins between host controller and the switch
interface retry_latch_if #(
  parameter int NCH   = 2,
  parameter int SEL_W = 1
);
  logic [NCH-1:0]   channel_input;       // host drives, high = on
  logic             diag_enable_pin;     // host drives diag enable
  logic [SEL_W-1:0] diag_channel_select; // host drives channel select
  logic             sense_output;        // device sense level
  logic             sense_oe;            // device drives sense when high

  modport device (
    input  channel_input,
    input  diag_enable_pin,
    input  diag_channel_select,
    output sense_output,
    output sense_oe
  );

  modport host (
    output channel_input,
    output diag_enable_pin,
    output diag_channel_select,
    input  sense_output,
    input  sense_oe
  );
endinterface
`default_nettype wire

/* src/retry_latch_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "retry_latch_consts.svh"
// switch-side retry and latch-off control, one fsm per channel
module retry_latch_device #(
  parameter int NCH       = `CHANNELS,
  parameter int SEL_W     = `SEL_WIDTH,
  parameter int CW        = `COUNT_WIDTH,
  parameter int LIMIT     = `RESTART_LIMIT,
  parameter int DW        = `CLEAR_CNT_WIDTH,
  parameter int DELAY_CYC = `CLEAR_DELAY_CYC,
  parameter int PW        = `PULSE_CNT_WIDTH,
  parameter int PULSE_CYC = `PULSE_MIN_CYC
) (
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  retry_latch_if.device      pins,
  input  wire logic [NCH-1:0] fault_in,
  output logic [NCH-1:0]      stage_on_out,
  output logic [NCH-1:0]      latched_out,
  output logic [NCH*CW-1:0]   restart_count_out
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [NCH-1:0]   in_meta_r;    // first stage, read only by in_r
  logic [NCH-1:0]   in_r;         // synchronised channel inputs
  logic             den_meta_r;   // first stage of diag enable
  logic             den_r;        // synchronised diag enable
  logic             den_d_r;      // previous den_r, for edges
  logic [SEL_W-1:0] sel_meta_r;   // first stage of channel select
  logic [SEL_W-1:0] sel_r;        // synchronised channel select

  // two flops on every pin, the pins come from another chip
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_meta_r  <= '0;
      in_r       <= '0;
      den_meta_r <= 1'b0;
      den_r      <= 1'b0;
      den_d_r    <= 1'b0;
      sel_meta_r <= '0;
      sel_r      <= '0;
    end else begin
      in_meta_r  <= pins.channel_input;
      in_r       <= in_meta_r;
      den_meta_r <= pins.diag_enable_pin;
      den_r      <= den_meta_r;
      den_d_r    <= den_r;
      sel_meta_r <= pins.diag_channel_select;
      sel_r      <= sel_meta_r;
    end
  end

  // ==========================================================
  // forced clear pulse detector
  // ==========================================================
  logic             den_rise;     // rising edge of diag enable
  logic             den_fall;     // falling edge of diag enable
  logic [SEL_W-1:0] psel_r;       // select captured at rising edge
  logic             psel_ok_r;    // select stayed put during pulse
  logic [PW-1:0]    pwidth_r;     // pulse width, saturating
  logic [NCH-1:0]   force_clr_r;  // one-cycle clear, per channel
  logic             pulse_long;   // pulse has reached minimum width

  assign den_rise   = den_r & ~den_d_r;
  assign den_fall   = ~den_r & den_d_r;
  assign pulse_long = (pwidth_r >= PW'(PULSE_CYC));

  // measure the pulse and watch the select while it is high
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      psel_r    <= '0;
      psel_ok_r <= 1'b0;
      pwidth_r  <= '0;
    end else if (den_rise) begin
      // start of pulse: latch select, restart width count
      psel_r    <= sel_r;
      psel_ok_r <= 1'b1;
      pwidth_r  <= '0;
    end else if (den_r) begin
      // saturate so long pulses never wrap back to short
      if (!pulse_long) begin
        pwidth_r <= pwidth_r + PW'(1);
      end
      if (sel_r != psel_r) begin
        psel_ok_r <= 1'b0;
      end
    end
  end

  // at the falling edge, clear only the selected channel
  // a too short pulse or a moved select is silently ignored
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      force_clr_r <= '0;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        force_clr_r[k] <= den_fall & psel_ok_r & pulse_long
                          & (psel_r == SEL_W'(k))
                          & (sel_r == psel_r)
                          & ~in_r[k];
      end
    end
  end

  // ==========================================================
  // per channel retry machine
  // ==========================================================
  logic [NCH-1:0] any_cnt;        // channel has counted a restart

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      retry_latch_pkg::chan_state_type state_r;   // current state
      retry_latch_pkg::chan_state_type state_nxt; // next state
      logic [CW-1:0] cnt_r;       // restarts since last clear
      logic [CW-1:0] cnt_nxt;     // next restart count
      logic [DW-1:0] low_r;       // cycles with input held low
      logic          timed_clr;   // input low long enough
      logic          clr;         // either clear mechanism

      assign timed_clr = ~in_r[g] & (low_r == DW'(DELAY_CYC - 1));
      assign clr       = timed_clr | force_clr_r[g];

      // low-time counter, stops once the delay is reached
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          low_r <= '0;
        end else if (in_r[g]) begin
          low_r <= '0;
        end else if (low_r != DW'(DELAY_CYC)) begin
          low_r <= low_r + DW'(1);
        end
      end

      // next state and count
      always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (clr) begin
          // input was low when the clear was set, so off is the right place
          state_nxt = retry_latch_pkg::CH_OFF;
          cnt_nxt   = '0;
        end else begin
          unique case (state_r)
            retry_latch_pkg::CH_OFF: begin
              // follows input regardless of supply range
              if (in_r[g]) begin
                state_nxt = retry_latch_pkg::CH_ON;
              end
            end
            retry_latch_pkg::CH_ON: begin
              if (!in_r[g]) begin
                state_nxt = retry_latch_pkg::CH_OFF;
              end else if (fault_in[g]) begin
                if (cnt_r >= CW'(LIMIT)) begin
                  state_nxt = retry_latch_pkg::CH_LATCH;
                end else begin
                  state_nxt = retry_latch_pkg::CH_RETRY;
                end
              end
            end
            retry_latch_pkg::CH_RETRY: begin
              // fault still set: stay off and wait
              if (!in_r[g]) begin
                state_nxt = retry_latch_pkg::CH_OFF;
              end else if (!fault_in[g]
                           && cnt_r < CW'(LIMIT)) begin
                state_nxt = retry_latch_pkg::CH_ON;
                cnt_nxt   = cnt_r + CW'(1);
              end
            end
            retry_latch_pkg::CH_LATCH: begin
              // only a clear gets the channel out
              state_nxt = retry_latch_pkg::CH_LATCH;
            end
          endcase
        end
      end

      // state, counter and registered outputs
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          state_r                 <= retry_latch_pkg::CH_OFF;
          cnt_r                   <= '0;
          stage_on_out[g]         <= 1'b0;
          latched_out[g]          <= 1'b0;
          restart_count_out[g*CW +: CW] <= '0;
        end else begin
          state_r         <= state_nxt;
          cnt_r           <= cnt_nxt;
          // stage is off the same edge the fault is seen
          stage_on_out[g] <= (state_nxt == retry_latch_pkg::CH_ON);
          latched_out[g]  <= (state_nxt == retry_latch_pkg::CH_LATCH);
          restart_count_out[g*CW +: CW] <= cnt_nxt;
        end
      end

      // after a clear the fsm starts at off: with the fault gone
      // it runs normally, with it present it retries from zero
      assign any_cnt[g] = (cnt_r != '0)
                        | (state_r == retry_latch_pkg::CH_LATCH);
    end
  endgenerate

  // ==========================================================
  // sense output
  // ==========================================================
  logic sense_r;   // fault flag of the selected channel
  logic oe_r;      // drive enable for sense

  // the real part gives an analog current here, this is a flag:
  // high while the selected channel has restarted or latched
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sense_r <= 1'b0;
      oe_r    <= 1'b0;
    end else begin
      oe_r    <= den_r;
      sense_r <= den_r & any_cnt[sel_r];
    end
  end

  assign pins.sense_output = sense_r;
  assign pins.sense_oe     = oe_r;

endmodule
`default_nettype wire

/* src/retry_latch_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "retry_latch_consts.svh"
// host-side pin driver with a forced clear sequencer
module retry_latch_host #(
  parameter int NCH       = `CHANNELS,
  parameter int SEL_W     = `SEL_WIDTH,
  parameter int PW        = `PULSE_CNT_WIDTH,
  parameter int PULSE_CYC = `PULSE_MAX_CYC,
  parameter int PREP_CYC  = `HOST_PREP_CYC
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  retry_latch_if.host           pins,
  input  wire logic [NCH-1:0]   on_req_in,
  input  wire logic             diag_on_in,
  input  wire logic [SEL_W-1:0] diag_sel_in,
  input  wire logic             clear_req_in,
  input  wire logic [SEL_W-1:0] clear_ch_in,
  output logic                  busy_out,
  output logic                  sense_out
);

  // ==========================================================
  // sequencer state
  // ==========================================================
  retry_latch_pkg::host_state_type st_r; // sequencer state
  logic [PW-1:0]    tmr_r;       // phase timer
  logic [SEL_W-1:0] ch_r;        // channel being cleared
  logic [NCH-1:0]   in_pin_r;    // channel input pins
  logic             den_pin_r;   // diag enable pin
  logic [SEL_W-1:0] sel_pin_r;   // channel select pin
  logic             s_meta_r;    // sense sync first stage
  logic             s_r;         // sense sync second stage

  // prep with enable low, pulse high, then one low cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= retry_latch_pkg::HS_IDLE;
      tmr_r <= '0;
      ch_r <= '0;
    end else begin
      unique case (st_r)
        retry_latch_pkg::HS_IDLE: begin
          if (clear_req_in) begin
            ch_r  <= clear_ch_in;
            tmr_r <= '0;
            st_r  <= retry_latch_pkg::HS_PREP;
          end
        end
        retry_latch_pkg::HS_PREP: begin
          tmr_r <= tmr_r + PW'(1);
          if (tmr_r == PW'(PREP_CYC - 1)) begin
            tmr_r <= '0;
            st_r  <= retry_latch_pkg::HS_PULSE;
          end
        end
        retry_latch_pkg::HS_PULSE: begin
          // past the longest minimum, so every part clears
          tmr_r <= tmr_r + PW'(1);
          if (tmr_r == PW'(PULSE_CYC)) begin
            st_r <= retry_latch_pkg::HS_DONE;
          end
        end
        retry_latch_pkg::HS_DONE: begin
          st_r <= retry_latch_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pin drivers
  // ==========================================================
  // during a clear the target input is held low, select fixed
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_pin_r  <= '0;
      den_pin_r <= 1'b0;
      sel_pin_r <= '0;
      busy_out  <= 1'b0;
    end else begin
      busy_out <= (st_r != retry_latch_pkg::HS_IDLE) | clear_req_in;
      if (st_r == retry_latch_pkg::HS_IDLE && !clear_req_in) begin
        in_pin_r  <= on_req_in;
        den_pin_r <= diag_on_in;
        sel_pin_r <= diag_sel_in;
      end else begin
        for (int k = 0; k < NCH; k++) begin
          in_pin_r[k] <= on_req_in[k] & (ch_sel() != SEL_W'(k));
        end
        den_pin_r <= (st_r == retry_latch_pkg::HS_PULSE);
        sel_pin_r <= ch_sel();
      end
    end
  end

  // channel under clear, valid from the request cycle on
  function automatic logic [SEL_W-1:0] ch_sel();
    return (st_r == retry_latch_pkg::HS_IDLE) ? clear_ch_in : ch_r;
  endfunction

  // sense comes from the other chip: three flops, gated by oe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_meta_r  <= 1'b0;
      s_r       <= 1'b0;
      sense_out <= 1'b0;
    end else begin
      s_meta_r  <= pins.sense_output & pins.sense_oe;
      s_r       <= s_meta_r;
      sense_out <= s_r;
    end
  end

  assign pins.channel_input       = in_pin_r;
  assign pins.diag_enable_pin     = den_pin_r;
  assign pins.diag_channel_select = sel_pin_r;

endmodule
`default_nettype wire

/* dv/retry_latch_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pin-level checker beside the host to device link
module retry_latch_assertions #(
  parameter int NCH       = 2,
  parameter int SEL_W     = 1,
  parameter int CW        = 3,
  parameter int DELAY_CYC = 50,
  parameter int PULSE_CYC = 5
) (
  input wire logic              clk_in,
  input wire logic              nrst_in,
  input wire logic [NCH-1:0]    channel_input,
  input wire logic              diag_enable_pin,
  input wire logic [SEL_W-1:0]  diag_channel_select,
  input wire logic              sense_oe,
  input wire logic [NCH-1:0]    fault_in,
  input wire logic [NCH-1:0]    stage_on_out,
  input wire logic [NCH-1:0]    latched_out,
  input wire logic [NCH*CW-1:0] restart_count_out
);
  logic [7:0] den_len_r; // high samples of diag enable so far
  logic [7:0] low_len_r; // low samples of channel 1 input so far

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // ==========================================================
  // helper counters; they saturate so a long run cannot wrap
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      den_len_r <= 8'h00;
    end else if (!diag_enable_pin) begin
      den_len_r <= 8'h00;
    end else if (den_len_r != 8'hff) begin
      den_len_r <= den_len_r + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_len_r <= 8'h00;
    end else if (channel_input[1]) begin
      low_len_r <= 8'h00;
    end else if (low_len_r != 8'hff) begin
      low_len_r <= low_len_r + 8'h01;
    end
  end

  // ==========================================================
  // forced clear of channel 0: held pulse, then the falling edge
  sequence s_pulse_held;
    (diag_enable_pin && !channel_input[0]
     && diag_channel_select == '0)[*6];
  endsequence
  sequence s_pulse_fall;
    !diag_enable_pin && !channel_input[0];
  endsequence

  property p_drop(int k);
    stage_on_out[k] && fault_in[k] |=> !stage_on_out[k];
  endproperty
  property p_step(logic [2:0] c);
    $changed(c) |-> c == $past(c) + 3'h1 || c == 3'h0;
  endproperty

  // ==========================================================
  // assertions
  a_sense_float: assert property (
    (!diag_enable_pin)[*4] |-> !sense_oe)
    else $error("sense driven with diag enable low");
  a_sense_drive: assert property (
    diag_enable_pin[*4] |-> sense_oe)
    else $error("sense not driven with diag enable high");
  a_stage_rise: assert property (
    $rose(stage_on_out[0]) |->
      $past(channel_input[0], 3) && !$past(latched_out[0]))
    else $error("stage 0 on without input or while latched");
  a_fault_drop0: assert property (p_drop(0))
    else $error("stage 0 stayed on under fault");
  a_fault_drop1: assert property (p_drop(1))
    else $error("stage 1 stayed on under fault");
  a_latch_full: assert property (
    latched_out[0] |->
      restart_count_out[2:0] == 3'h6 && !stage_on_out[0])
    else $error("latch without six restarts or with stage on");
  a_count_step0: assert property (p_step(restart_count_out[2:0]))
    else $error("count 0 moved other than up by one or clear");
  a_count_step1: assert property (p_step(restart_count_out[5:3]))
    else $error("count 1 moved other than up by one or clear");
  a_forced_clear: assert property (
    s_pulse_held ##1 s_pulse_fall |->
      ##[1:6] (restart_count_out[2:0] == 3'h0 && !latched_out[0]))
    else $error("forced clear left channel 0 counted");
  a_timed_clear: assert property (
    low_len_r == DELAY_CYC + 6 |->
      restart_count_out[5:3] == 3'h0 && !latched_out[1])
    else $error("long input low left channel 1 counted");
  a_sel_hold: assert property (
    $past(diag_enable_pin) |-> $stable(diag_channel_select))
    else $error("select moved across diag pulse");
  a_pulse_width: assert property (
    $fell(diag_enable_pin) |-> den_len_r >= PULSE_CYC)
    else $error("diag pulse shorter than minimum");
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench: host and device joined pin to pin
module tb_top;
  localparam int DLY = 50; // clear delay shortened for simulation
  localparam int DPW = 5;  // device minimum pulse, cycles
  logic       clk_in;      // 25 MHz clock
  logic       nrst_in;     // async reset, active low
  logic [1:0] on_req;      // wanted channel inputs
  logic       diag_on;     // wanted diag enable
  logic       diag_sel;    // wanted channel select
  logic       clear_req;   // forced clear start
  logic       clear_ch;    // channel to force clear
  logic [1:0] fault_in;    // injected faults
  logic [1:0] stage_on;    // output stages
  logic [1:0] latched;     // latch-off flags
  logic [5:0] count;       // restart counts
  logic       busy;        // host sequencer busy
  logic       sense;       // sense flag at host
  logic [7:0] notes[$];    // expected {latched, counts}
  logic [7:0] prev;        // last seen {latched, counts}
  int         n_fail;
  int         check_count;
  int         seed;
  int         i;

  retry_latch_if link ();

  retry_latch_device #(.DELAY_CYC(DLY), .PULSE_CYC(DPW))
    retry_latch_device_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .pins(link.device),
    .fault_in(fault_in), .stage_on_out(stage_on),
    .latched_out(latched), .restart_count_out(count));

  // host pulse must outlast the device minimum
  retry_latch_host #(.PULSE_CYC(8)) retry_latch_host_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .pins(link.host),
    .on_req_in(on_req), .diag_on_in(diag_on), .diag_sel_in(diag_sel),
    .clear_req_in(clear_req), .clear_ch_in(clear_ch),
    .busy_out(busy), .sense_out(sense));

  // checker defaults already match the shortened delay and pulse
  retry_latch_assertions retry_latch_assertions_inst (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .channel_input(link.channel_input),
    .diag_enable_pin(link.diag_enable_pin),
    .diag_channel_select(link.diag_channel_select),
    .sense_oe(link.sense_oe), .fault_in(fault_in),
    .stage_on_out(stage_on), .latched_out(latched),
    .restart_count_out(count));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // bounded wait for a stage level; a stuck stage ends the run
  task automatic wait_on(input int k, input logic v);
    int n;
    n = 0;
    while (stage_on[k] !== v && n < 200) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 200) begin
      chk("stage_wait", v, stage_on[k]);
      results();
    end
  endtask

  // bounded wait for the host sequencer; a stuck one ends the run
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    chk("busy", 8'h00, busy);
    if (busy !== 1'b0) begin
      results();
    end
  endtask

  // one fault of random length once the stage is on
  task automatic fault_pulse(input int k);
    wait_on(k, 1'b1);
    fault_in[k] <= 1'b1;
    repeat (1 + $unsigned($random(seed)) % 2) @(posedge clk_in);
    fault_in[k] <= 1'b0;
    @(posedge clk_in);
  endtask

  // ==========================================================
  // monitor: each change of flags or counts uses up one note
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      prev <= 8'h00;
    end else if ({latched, count} !== prev) begin
      prev <= {latched, count};
      if (notes.size() == 0) begin
        chk("unexpected", prev, {latched, count});
      end else begin
        chk("latch_count", notes.pop_front(), {latched, count});
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 34;
    n_fail = 0;
    check_count = 0;
    nrst_in = 1'b0;
    on_req = 2'b00;
    diag_on = 1'b0;
    diag_sel = 1'b0;
    clear_req = 1'b0;
    clear_ch = 1'b0;
    fault_in = 2'b00;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    on_req <= 2'b11;
    wait_on(1, 1'b1);
    // six restarts on channel 0, the seventh fault latches it
    for (i = 1; i <= 6; i++) begin
      notes.push_back({5'h00, i[2:0]});
      fault_pulse(0);
    end
    notes.push_back(8'h46);
    fault_pulse(0);
    repeat (10) @(posedge clk_in);
    chk("stage0", 8'h00, stage_on[0]);
    // one restart on channel 1 so its count must survive
    notes.push_back(8'h4e);
    fault_pulse(1);
    // forced clear of channel 0 only
    notes.push_back(8'h08);
    clear_req <= 1'b1;
    @(posedge clk_in);
    clear_req <= 1'b0;
    repeat (2) @(posedge clk_in);
    wait_idle();
    wait_on(0, 1'b1);
    // sense flag follows diag enable for a counted channel
    diag_sel <= 1'b1;
    diag_on <= 1'b1;
    repeat (12) @(posedge clk_in);
    chk("sense_on", 8'h01, sense);
    diag_on <= 1'b0;
    repeat (12) @(posedge clk_in);
    chk("sense_off", 8'h00, sense);
    // short low keeps the count, long low clears it
    diag_sel <= 1'b0;
    on_req[1] <= 1'b0;
    repeat (20) @(posedge clk_in);
    on_req[1] <= 1'b1;
    wait_on(1, 1'b1);
    on_req[1] <= 1'b0;
    notes.push_back(8'h00);
    repeat (DLY + 20) @(posedge clk_in);
    // fault still there: retry sequence starts again from zero
    fault_in[1] <= 1'b1;
    on_req[1] <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk("stage1", 8'h00, stage_on[1]);
    notes.push_back(8'h08);
    fault_in[1] <= 1'b0;
    wait_on(1, 1'b1);
    repeat (4) @(posedge clk_in);
    // forced clear of channel 1 leaves channel 0 counted and on
    notes.push_back(8'h09);
    fault_pulse(0);
    notes.push_back(8'h01);
    clear_ch <= 1'b1;
    clear_req <= 1'b1;
    @(posedge clk_in);
    clear_req <= 1'b0;
    repeat (2) @(posedge clk_in);
    wait_idle();
    wait_on(1, 1'b1);
    chk("stage0_kept", 8'h01, stage_on[0]);
    repeat (4) @(posedge clk_in);
    chk("notes_left", 8'h00, 8'(notes.size()));
    results();
  end
endmodule
`default_nettype wire
